/* File: isf_defines.svh */
// What this block does
// - Set tx_empty when buffer moves to shifter after ACK, not address, NACK, checksum.
// - Clear tx_empty on data_buffer write, start, stop or unit_on low.
// - Keep tx_empty set on first write or a write while byte_done_stall.
// - Set rx_full on shifter copy after ACK in receive, never address or lost arbitration.
// - Clear rx_full on data_buffer access or off; a read during stall keeps it.
// - Slave sets stop_seen_flag on stop after acknowledge, not after a NACK.
// - Clear stop_seen_flag by stat_one read then control_two write, or off.
// - Master ten-bit header sets ten_bit_header_sent; stat_one read then buffer write clears.
// - Set byte_done_stall with stretching when buffer unread or unwritten; not NACK, lost, checksum.
// - Clear byte_done_stall by stat_one read then buffer access, start/stop sending, off.
// - Slave sets address flag on own, general call or bus-management match.
// - Master sets address flag after ACK of last address byte, never after NACK.
// - Clear address flag by stat_one read then stat_three read, or off.
// - Master sets start_sent_flag on start; stat_one read then buffer write clears.
// - Set alert_line_event on host alert pin or slave alert header; zero write clears.
// - Timeout on 25 ms low or long extension; slave releases, master stops.
// - Set halt_wakeup on halt match or master halt entry, only with event_irq_on.
// - Checksum mismatch flags checksum_mismatch and forces NACK; match acks if enabled.
// - Slave without stretching flags overrun_underrun, drops byte or resends previous.
// - Set ack_fail on missing acknowledge; zero write or off clears.
// - On lost arbitration set lost_arbitration and drop master_mode_ind.
// - Set misplaced_cond_err on misplaced data edge with clock high; zero write clears.
// - Stretch clock while address or stall flag set, unless slave stretching disabled.
`ifndef ISF_DEFINES_SVH
`define ISF_DEFINES_SVH
`define ISF_OFF_CTRL 8'h00
`define ISF_OFF_CTRL_TWO 8'h01
`define ISF_OFF_DATA 8'h06
`define ISF_OFF_STAT_ONE 8'h07
`define ISF_OFF_STAT_TWO 8'h08
`define ISF_OFF_STAT_THREE 8'h09
`define ISF_OFF_IRQ_CFG 8'h0A
`define ISF_RST_BYTE 8'h00
`define ISF_S1_TXE 7
`define ISF_S1_RX_FULL 6
`define ISF_S1_STOP 4
`define ISF_S1_HDR10 3
`define ISF_S1_BTF 2
`define ISF_S1_ADDR 1
`define ISF_S1_SB 0
`define ISF_S2_ALERT 7
`define ISF_S2_TOUT 6
`define ISF_S2_WAKE 5
`define ISF_S2_PEC 4
`define ISF_S2_OVR 3
`define ISF_S2_AF 2
`define ISF_S2_LOST_ARBITRATION 1
`define ISF_S2_MISPLACED_COND_ERR 0
`define ISF_CTRL_ON 0
`define ISF_CTRL_HOST 3
`define ISF_CTRL_HOLD_DIS 7
`define ISF_CTL2_ACK 2
`define ISF_IRQ_EVT 1
`define ISF_S3_MSL 0
`define ISF_CLK_HZ 10000000
`define ISF_LOW_MS 25
`define ISF_MEXT_MS 10
`define ISF_SEXT_MS 25
`define ISF_LOW_CYC (`ISF_LOW_MS * `ISF_CLK_HZ / 1000)
`define ISF_MEXT_CYC (`ISF_MEXT_MS * `ISF_CLK_HZ / 1000)
`define ISF_SEXT_CYC (`ISF_SEXT_MS * `ISF_CLK_HZ / 1000)
`define ISF_CNT_W 18
`endif

/* File: isf_far_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Byte engine and far side stand-in
// ----------------------------------------
// Each request becomes one event pulse one cycle later, as the engine does.
module isf_far_model
   import isf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [3:0] kind,
   input wire logic master,
   input wire logic scl_low,
   input wire logic [7:0] rxb,
   output isf_evt_type evt,
   output logic scl_line,
   output logic alert_n
);
   // The bus lines have pull-ups, so a released line reads high.
   assign scl_line = !scl_low;
   assign alert_n = 1'b1;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt <= '0;
      end else begin
         evt <= '0;
         evt.is_master <= master;
         evt.rx_byte <= rxb;
         if (go) begin
            case (kind)
               4'h0: evt.start_sent <= 1'b1;
               4'h1: evt.stop_det <= 1'b1;
               4'h2: evt.addr_match <= 1'b1;
               4'h3: evt.tx_copy <= 1'b1;
               4'h4: evt.tx_need <= 1'b1;
               4'h5: evt.rx_done <= 1'b1;
               4'h6: evt.nack <= 1'b1;
               4'h7: evt.arb_lost <= 1'b1;
               default: evt.misplaced <= 1'b1;
            endcase
         end
      end
   end
endmodule

/* File: isf_flags.sv */
`timescale 1ns/10ps
`include "isf_defines.svh"
module isf_flags
   import isf_pkg::*;
#(
   parameter int LOW_CYC = `ISF_LOW_CYC,
   parameter int MEXT_CYC = `ISF_MEXT_CYC,
   parameter int SEXT_CYC = `ISF_SEXT_CYC
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire isf_bus_type bus,
   output logic [7:0] rd_data,
   input wire isf_evt_type evt,
   input wire logic scl_pin,
   input wire logic alert_pin_n,
   output logic [7:0] tx_byte,
   output isf_ctl_type ctl
);
   // ------------------------------------------------------------
   // Register access decode
   // ------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_two_r, irq_cfg_r, dbuf_r;
   logic tx_empty_r, rx_full_r, stop_r, hdr10_r, btf_r, addr_r, sb_r;
   logic alert_r, tout_r, wake_r, pec_r, ovr_r, af_r, lost_arbitration_r, misplaced_cond_err_r;
   logic mst_r;
   isf_arm_type arm_r;
   logic [7:0] stat_one, stat_two;
   logic unit_on, hold_dis, ack_en, host, armed;
   logic wr_data, rd_data_acc, wr_ctl2, rd_s1, rd_s3, wr_s2, any_acc;
   logic seq_dr_wr, seq_dr_rd, seq_ctl2, seq_s3;
   logic scl_m_r, scl_s_r, alert_m_r, alert_s_r, alert_old_r;
   logic [`ISF_CNT_W-1:0] low_cnt_r, ext_cnt_r;
   logic low_hit, ext_hit, tout_set;
   logic no_stretch_slave, rx_copy;

   assign unit_on = ctrl_r[`ISF_CTRL_ON];
   assign hold_dis = ctrl_r[`ISF_CTRL_HOLD_DIS];
   assign host = ctrl_r[`ISF_CTRL_HOST];
   assign ack_en = ctrl_two_r[`ISF_CTL2_ACK];
   assign wr_data = bus.wr && bus.addr == `ISF_OFF_DATA;
   assign rd_data_acc = bus.rd && bus.addr == `ISF_OFF_DATA;
   assign wr_ctl2 = bus.wr && bus.addr == `ISF_OFF_CTRL_TWO;
   assign wr_s2 = bus.wr && bus.addr == `ISF_OFF_STAT_TWO;
   assign rd_s1 = bus.rd && bus.addr == `ISF_OFF_STAT_ONE;
   assign rd_s3 = bus.rd && bus.addr == `ISF_OFF_STAT_THREE;
   assign any_acc = bus.rd || bus.wr;
   assign armed = arm_r == ARM_READY;
   assign seq_dr_wr = armed && wr_data;
   assign seq_dr_rd = armed && rd_data_acc;
   assign seq_ctl2 = armed && wr_ctl2;
   assign seq_s3 = armed && rd_s3;
   assign no_stretch_slave = hold_dis && !evt.is_master;
   assign rx_copy = evt.rx_done && !evt.arb_lost && !evt.nack;

   always_comb begin
      stat_one = `ISF_RST_BYTE;
      stat_one[`ISF_S1_TXE] = tx_empty_r;
      stat_one[`ISF_S1_RX_FULL] = rx_full_r;
      stat_one[`ISF_S1_STOP] = stop_r;
      stat_one[`ISF_S1_HDR10] = hdr10_r;
      stat_one[`ISF_S1_BTF] = btf_r;
      stat_one[`ISF_S1_ADDR] = addr_r;
      stat_one[`ISF_S1_SB] = sb_r;
      stat_two = `ISF_RST_BYTE;
      stat_two[`ISF_S2_ALERT] = alert_r;
      stat_two[`ISF_S2_TOUT] = tout_r;
      stat_two[`ISF_S2_WAKE] = wake_r;
      stat_two[`ISF_S2_PEC] = pec_r;
      stat_two[`ISF_S2_OVR] = ovr_r;
      stat_two[`ISF_S2_AF] = af_r;
      stat_two[`ISF_S2_LOST_ARBITRATION] = lost_arbitration_r;
      stat_two[`ISF_S2_MISPLACED_COND_ERR] = misplaced_cond_err_r;
   end

   // ------------------------------------------------------------
   // Control registers and read port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `ISF_RST_BYTE;
         ctrl_two_r <= `ISF_RST_BYTE;
         irq_cfg_r <= `ISF_RST_BYTE;
      end else if (bus.wr) begin
         case (bus.addr)
            `ISF_OFF_CTRL: ctrl_r <= bus.wdata;
            `ISF_OFF_CTRL_TWO: ctrl_two_r <= bus.wdata;
            `ISF_OFF_IRQ_CFG: irq_cfg_r <= bus.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= `ISF_RST_BYTE;
      end else if (bus.rd) begin
         case (bus.addr)
            `ISF_OFF_CTRL: rd_data <= ctrl_r;
            `ISF_OFF_CTRL_TWO: rd_data <= ctrl_two_r;
            `ISF_OFF_IRQ_CFG: rd_data <= irq_cfg_r;
            `ISF_OFF_DATA: rd_data <= dbuf_r;
            `ISF_OFF_STAT_ONE: rd_data <= stat_one;
            `ISF_OFF_STAT_TWO: rd_data <= stat_two;
            `ISF_OFF_STAT_THREE: rd_data <= {7'h00, mst_r};
            default: rd_data <= `ISF_RST_BYTE;
         endcase
      end else begin
         rd_data <= `ISF_RST_BYTE;
      end
   end

   // Any access other than a stat_one read drops the armed state, the matching one included.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm_r <= ARM_IDLE;
      end else begin
         case (arm_r)
            ARM_IDLE: if (rd_s1) arm_r <= ARM_READY;
            ARM_READY: if (any_acc && !rd_s1) arm_r <= ARM_IDLE;
            default: arm_r <= ARM_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Data buffer
   // ------------------------------------------------------------
   // A byte arriving while the buffer is full is dropped without stretching.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dbuf_r <= `ISF_RST_BYTE;
      end else if (wr_data) begin
         dbuf_r <= bus.wdata;
      end else if (rx_copy && !(rx_full_r && no_stretch_slave)) begin
         dbuf_r <= evt.rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Transfer event flags
   // ------------------------------------------------------------
   // Clears come first so that a same-cycle set wins, except the off clear and the mst_r clear on stop or lost arbitration.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_empty_r <= 1'b0;
      end else if (!unit_on) begin
         tx_empty_r <= 1'b0;
      end else begin
         if (evt.start_sent || evt.stop_det) tx_empty_r <= 1'b0;
         if (wr_data && !evt.shift_idle && !btf_r) begin
            tx_empty_r <= 1'b0;
         end
         if (evt.tx_copy && !evt.nack && !evt.pec_next) begin
            tx_empty_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_r <= 1'b0;
      end else if (!unit_on) begin
         rx_full_r <= 1'b0;
      end else begin
         if (wr_data || (rd_data_acc && !btf_r)) rx_full_r <= 1'b0;
         if (rx_copy) rx_full_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_r <= 1'b0;
      end else if (!unit_on) begin
         stop_r <= 1'b0;
      end else begin
         if (seq_ctl2) stop_r <= 1'b0;
         if (evt.stop_det && !evt.is_master && ack_en && !evt.nack) begin
            stop_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr10_r <= 1'b0;
      end else if (!unit_on) begin
         hdr10_r <= 1'b0;
      end else begin
         if (seq_dr_wr) hdr10_r <= 1'b0;
         if (evt.hdr10_sent && evt.is_master && !evt.nack) begin
            hdr10_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         btf_r <= 1'b0;
      end else if (!unit_on) begin
         btf_r <= 1'b0;
      end else begin
         if (seq_dr_wr || seq_dr_rd) btf_r <= 1'b0;
         if ((evt.start_sent || evt.stop_det) && tx_empty_r) begin
            btf_r <= 1'b0;
         end
         if (!no_stretch_slave && !evt.nack && !evt.arb_lost &&
             ((evt.rx_done && rx_full_r) ||
              (evt.tx_need && tx_empty_r && !evt.pec_next))) begin
            btf_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 1'b0;
      end else if (!unit_on) begin
         addr_r <= 1'b0;
      end else begin
         if (seq_s3) addr_r <= 1'b0;
         if (evt.addr_match && !evt.is_master) addr_r <= 1'b1;
         if (evt.addr_acked && evt.is_master && !evt.nack) begin
            addr_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sb_r <= 1'b0;
      end else if (!unit_on) begin
         sb_r <= 1'b0;
      end else begin
         if (seq_dr_wr) sb_r <= 1'b0;
         if (evt.start_sent && evt.is_master) sb_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_r <= 1'b0;
      end else if (!unit_on || evt.stop_det || evt.arb_lost) begin
         mst_r <= 1'b0;
      end else if (evt.start_sent) begin
         mst_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers and timeout counters
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         alert_m_r <= 1'b1;
         alert_s_r <= 1'b1;
         alert_old_r <= 1'b1;
      end else begin
         scl_m_r <= scl_pin;
         scl_s_r <= scl_m_r;
         alert_m_r <= alert_pin_n;
         alert_s_r <= alert_m_r;
         alert_old_r <= alert_s_r;
      end
   end

   assign low_hit = low_cnt_r == LOW_CYC[`ISF_CNT_W-1:0];
   assign ext_hit = ext_cnt_r ==
      (evt.is_master ? MEXT_CYC[`ISF_CNT_W-1:0] : SEXT_CYC[`ISF_CNT_W-1:0]);
   assign tout_set = unit_on && (low_hit || ext_hit);

   // Counters saturate, so a stuck line holds tout_set and sets the flag again after each clear.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_r <= '0;
      end else if (!unit_on || scl_s_r) begin
         low_cnt_r <= '0;
      end else if (!low_hit) begin
         low_cnt_r <= low_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_cnt_r <= '0;
      end else if (!unit_on || evt.start_sent || evt.stop_det) begin
         ext_cnt_r <= '0;
      end else if (evt.low_ext && !ext_hit) begin
         ext_cnt_r <= ext_cnt_r + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Error flags, write zero to clear
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_r <= 1'b0;
         tout_r <= 1'b0;
         wake_r <= 1'b0;
         pec_r <= 1'b0;
         ovr_r <= 1'b0;
         af_r <= 1'b0;
         lost_arbitration_r <= 1'b0;
         misplaced_cond_err_r <= 1'b0;
      end else if (!unit_on) begin
         alert_r <= 1'b0;
         tout_r <= 1'b0;
         wake_r <= 1'b0;
         pec_r <= 1'b0;
         ovr_r <= 1'b0;
         af_r <= 1'b0;
         lost_arbitration_r <= 1'b0;
         misplaced_cond_err_r <= 1'b0;
      end else begin
         if (wr_s2) begin
            alert_r <= alert_r & bus.wdata[`ISF_S2_ALERT];
            tout_r <= tout_r & bus.wdata[`ISF_S2_TOUT];
            wake_r <= wake_r & bus.wdata[`ISF_S2_WAKE];
            pec_r <= pec_r & bus.wdata[`ISF_S2_PEC];
            ovr_r <= ovr_r & bus.wdata[`ISF_S2_OVR];
            af_r <= af_r & bus.wdata[`ISF_S2_AF];
            lost_arbitration_r <= lost_arbitration_r & bus.wdata[`ISF_S2_LOST_ARBITRATION];
            misplaced_cond_err_r <= misplaced_cond_err_r & bus.wdata[`ISF_S2_MISPLACED_COND_ERR];
         end
         if ((host && alert_old_r && !alert_s_r) ||
             (!host && evt.alert_hdr)) begin
            alert_r <= 1'b1;
         end
         if (tout_set) tout_r <= 1'b1;
         if (irq_cfg_r[`ISF_IRQ_EVT] &&
             ((evt.halt_match && !evt.is_master) ||
              (evt.halt_entry && evt.is_master))) begin
            wake_r <= 1'b1;
         end
         if (evt.pec_check && evt.pec_bad) pec_r <= 1'b1;
         if (no_stretch_slave && ((evt.rx_done && rx_full_r) ||
             (evt.tx_need && tx_empty_r))) begin
            ovr_r <= 1'b1;
         end
         if (evt.nack) af_r <= 1'b1;
         if (evt.arb_lost) lost_arbitration_r <= 1'b1;
         if (evt.misplaced) misplaced_cond_err_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Controls back to the bus engine
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= '0;
         tx_byte <= `ISF_RST_BYTE;
      end else begin
         ctl.stretch <= unit_on && (addr_r || btf_r) && !no_stretch_slave;
         ctl.ack_drive <= evt.pec_check ? (ack_en && !evt.pec_bad) : ack_en;
         ctl.resend <= no_stretch_slave && evt.tx_need && tx_empty_r;
         ctl.slave_release <= tout_set && !evt.is_master;
         ctl.master_stop <= tout_set && evt.is_master;
         ctl.master_mode_ind <= mst_r;
         tx_byte <= dbuf_r;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_arm;
      bus.rd && bus.addr == `ISF_OFF_STAT_ONE;
   endsequence
   sequence s_s3_read;
      bus.rd && bus.addr == `ISF_OFF_STAT_THREE && unit_on &&
      !evt.addr_match && !evt.addr_acked;
   endsequence
   property p_txe_set;
      @(posedge sys_clk) disable iff (!rst_n)
      unit_on && evt.tx_copy && !evt.nack && !evt.pec_next |=> tx_empty_r;
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("tx_empty not set");
   property p_txe_start;
      @(posedge sys_clk) disable iff (!rst_n)
      unit_on && evt.start_sent && !evt.tx_copy |=> !tx_empty_r;
   endproperty
   a_txe_start: assert property (p_txe_start) else $error("tx_empty kept");
   property p_rx_full_src;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rx_full_r) |-> $past(evt.rx_done && !evt.arb_lost);
   endproperty
   a_rx_full_src: assert property (p_rx_full_src) else $error("rx_full bad");
   property p_addr_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      s_arm ##1 s_s3_read |=> !addr_r;
   endproperty
   a_addr_clear: assert property (p_addr_clear) else $error("addr kept");
   property p_sb_src;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(sb_r) |-> $past(evt.start_sent && evt.is_master);
   endproperty
   a_sb_src: assert property (p_sb_src) else $error("start flag bad");
   property p_lost_arbitration;
      @(posedge sys_clk) disable iff (!rst_n)
      unit_on && evt.arb_lost |=> lost_arbitration_r && !mst_r ##1 !ctl.master_mode_ind;
   endproperty
   a_lost_arbitration: assert property (p_lost_arbitration) else $error("arbitration loss");
   property p_tout_slave;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(tout_r) && !evt.is_master && !$past(evt.is_master)
      |-> ctl.slave_release;
   endproperty
   a_tout_slave: assert property (p_tout_slave) else $error("no release");
   property p_off_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      !unit_on |=> stat_one == `ISF_RST_BYTE && stat_two == `ISF_RST_BYTE;
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("flags kept");
   property p_stop_src;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(stop_r) |-> $past(evt.stop_det && ack_en && !evt.nack);
   endproperty
   a_stop_src: assert property (p_stop_src) else $error("stop flag bad");
   property p_stretch;
      @(posedge sys_clk) disable iff (!rst_n)
      unit_on && btf_r && !hold_dis |=> ctl.stretch;
   endproperty
   a_stretch: assert property (p_stretch) else $error("no stretch");
endmodule

/* File: isf_flags_bench.sv */
`timescale 1ns/10ps
module isf_flags_bench;
   import isf_pkg::*;
   logic sys_clk, rst_n, go, master, scl_low, scl_line, alert_n;
   logic [3:0] kind;
   logic [7:0] rxb, rd_data, tx_byte;
   isf_bus_type bus;
   isf_evt_type evt;
   isf_ctl_type ctl;
   int bad_count = 0;
   int n_compared = 0;
   isf_flags #(.LOW_CYC(40), .MEXT_CYC(20), .SEXT_CYC(30)) isf_flags_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
      .evt(evt), .scl_pin(scl_line), .alert_pin_n(alert_n),
      .tx_byte(tx_byte), .ctl(ctl));
   isf_far_model isf_far_model_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .go(go), .kind(kind),
      .master(master), .scl_low(scl_low), .rxb(rxb), .evt(evt),
      .scl_line(scl_line), .alert_n(alert_n));
   // ----------------------------------------
   // Clock, access tasks and checks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = !sys_clk;
   end
   task automatic stop_test();
      $display("mismatches %0d, compared %0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // An idle cycle follows every access, which also spaces clear steps.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge sys_clk);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rd_data, exp);
   endtask
   task automatic fire(input logic [3:0] k);
      @(posedge sys_clk);
      kind <= k;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      #(3000 * 100);
      bad_count++;
      stop_test();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      bus = '0;
      go = 1'b0;
      kind = 4'h0;
      master = 1'b1;
      scl_low = 1'b0;
      rxb = 8'h00;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      acc(1'b1, 8'h00, 8'h01);
      acc(1'b1, 8'h01, 8'h04);
      fire(4'h0);
      rd(8'h07, 8'h01);
      acc(1'b1, 8'h06, 8'hA5);
      rd(8'h07, 8'h00);
      chk(tx_byte, 8'hA5);
      fire(4'h3);
      rd(8'h07, 8'h80);
      fire(4'h4);
      rd(8'h07, 8'h84);
      chk({7'h00, ctl.stretch}, 8'h01);
      acc(1'b0, 8'h06, 8'h00);
      rd(8'h07, 8'h80);
      acc(1'b1, 8'h06, 8'h3C);
      rd(8'h07, 8'h00);
      master <= 1'b0;
      rxb <= 8'h5A;
      fire(4'h5);
      rd(8'h07, 8'h40);
      rd(8'h06, 8'h5A);
      rd(8'h07, 8'h00);
      fire(4'h2);
      rd(8'h07, 8'h02);
      rd(8'h08, 8'h00);
      acc(1'b0, 8'h09, 8'h00);
      rd(8'h07, 8'h02);
      acc(1'b0, 8'h09, 8'h00);
      rd(8'h07, 8'h00);
      fire(4'h1);
      rd(8'h07, 8'h10);
      rd(8'h08, 8'h00);
      acc(1'b1, 8'h01, 8'h04);
      rd(8'h07, 8'h10);
      acc(1'b1, 8'h01, 8'h04);
      rd(8'h07, 8'h00);
      fire(4'h6);
      fire(4'h7);
      fire(4'h8);
      rd(8'h08, 8'h07);
      acc(1'b1, 8'h08, 8'hFA);
      rd(8'h08, 8'h02);
      acc(1'b1, 8'h08, 8'h00);
      rd(8'h08, 8'h00);
      scl_low <= 1'b1;
      repeat (60) @(posedge sys_clk);
      scl_low <= 1'b0;
      rd(8'h08, 8'h40);
      fire(4'h5);
      acc(1'b1, 8'h00, 8'h00);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      stop_test();
   end
endmodule

/* File: isf_pkg.sv */
package isf_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } isf_bus_type;
   typedef struct packed {
      logic is_master;
      logic shift_idle;
      logic start_sent;
      logic stop_det;
      logic hdr10_sent;
      logic addr_acked;
      logic addr_match;
      logic tx_need;
      logic tx_copy;
      logic rx_done;
      logic [7:0] rx_byte;
      logic nack;
      logic arb_lost;
      logic misplaced;
      logic pec_next;
      logic pec_check;
      logic pec_bad;
      logic alert_hdr;
      logic halt_match;
      logic halt_entry;
      logic low_ext;
   } isf_evt_type;
   typedef struct packed {
      logic stretch;
      logic ack_drive;
      logic resend;
      logic slave_release;
      logic master_stop;
      logic master_mode_ind;
   } isf_ctl_type;
   typedef enum logic {ARM_IDLE, ARM_READY} isf_arm_type;
endpackage
